//--- logic/srms_pkg.sv
// Package for the request memory-type decoder and status word reporter.
// Assumes a single 25 MHz clock domain; shared by the top and its memory.
package srms_pkg;
	// Memory-type codes, word unit
	localparam logic [7:0] MT_REG_WORD   = 8'h08;
	localparam logic [7:0] MT_AIN_WORD   = 8'h0A;
	localparam logic [7:0] MT_AOUT_WORD  = 8'h0C;
	// Bit unit
	localparam logic [7:0] MT_IN_BIT     = 8'h46;
	localparam logic [7:0] MT_OUT_BIT    = 8'h48;
	localparam logic [7:0] MT_TMP_BIT    = 8'h4A;
	localparam logic [7:0] MT_INT_BIT    = 8'h4C;
	localparam logic [7:0] MT_SDA_BIT    = 8'h4E;
	localparam logic [7:0] MT_SDB_BIT    = 8'h50;
	localparam logic [7:0] MT_SDC_BIT    = 8'h52;
	localparam logic [7:0] MT_SYS_BIT    = 8'h54;
	localparam logic [7:0] MT_GLB_BIT    = 8'h56;
	// Byte unit
	localparam logic [7:0] MT_IN_BYTE    = 8'h10;
	localparam logic [7:0] MT_OUT_BYTE   = 8'h12;
	localparam logic [7:0] MT_TMP_BYTE   = 8'h14;
	localparam logic [7:0] MT_INT_BYTE   = 8'h16;
	localparam logic [7:0] MT_SDA_BYTE   = 8'h18;
	localparam logic [7:0] MT_SDB_BYTE   = 8'h1A;
	localparam logic [7:0] MT_SDC_BYTE   = 8'h1C;
	localparam logic [7:0] MT_SYS_BYTE   = 8'h1E;
	localparam logic [7:0] MT_GLB_BYTE   = 8'h38;
	// Status word codes
	localparam logic [7:0] MAJ_OK        = 8'h01;
	localparam logic [7:0] MIN_NONE      = 8'h00;
	localparam logic [7:0] MAJ_SRV_ERR   = 8'h05;
	localparam logic [7:0] MAJ_BUSY      = 8'h07;
	localparam logic [7:0] MIN_BAD_PARAM = 8'hF4;
	localparam logic [7:0] MIN_NO_PRIV   = 8'hFE;
	localparam logic [7:0] MIN_ABORT     = 8'hFF;
	// Reset values and sizes
	localparam logic [15:0] STATUS_RST   = 16'h0000;
	localparam logic [15:0] ADDR_FIRST   = 16'h0001;
	localparam logic [15:0] MAX_DEF      = 16'h2000;
	localparam int          NUM_AREAS    = 13;
	localparam int          AREA_W       = 4;
	localparam logic [3:0]  AREA_NONE    = 4'hF;

	typedef enum logic [1:0] {
		UNIT_WORD = 2'h0,
		UNIT_BIT  = 2'h1,
		UNIT_BYTE = 2'h2,
		UNIT_BAD  = 2'h3
	} srms_unit_e;
endpackage

//--- logic/srms_limit_mem.sv
// Small table of per-area upper address limits.
// Assumes one clock; read data registered, one-cycle latency.
`timescale 1ns/100ps
`default_nettype none
module srms_limit_mem
	import srms_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_rst,
	// Write port
	input  wire logic                i_wr_en,
	input  wire logic [AREA_W-1:0]   i_wr_area,
	input  wire logic [15:0]         i_wr_max,
	// Read port
	input  wire logic [AREA_W-1:0]   i_rd_area,
	output var  logic [15:0]         o_rd_max
);
	logic [15:0] mem_r [0:NUM_AREAS-1];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < NUM_AREAS; k++) begin
				mem_r[k] <= MAX_DEF;
			end
			o_rd_max <= 16'h0000;
		end else begin
			if (i_wr_en && (i_wr_area < AREA_W'(NUM_AREAS))) begin
				mem_r[i_wr_area] <= i_wr_max;
			end
			// Unknown area reads zero so every address fails the range test
			if (i_rd_area < AREA_W'(NUM_AREAS)) begin
				o_rd_max <= mem_r[i_rd_area];
			end else begin
				o_rd_max <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

//--- logic/srms_top.sv
// Request memory-type decoder and status word reporter.
// Assumes the CPU side presents one request per pulse and a transfer
// engine that reports its own completion with a major/minor code pair.
//
// Overview of operation
// - Codes 08h/0Ah/0Ch select word-unit tables
// - Codes 46h..56h select bit-unit discrete areas
// - Codes 10h..1Ch,1Eh,38h select byte-unit discrete areas
// - Byte types count offset and length in bytes
// - System discretes 54h/1Eh reject writes
// - Addresses valid from 1 to configurable maximum
// - Bit or byte choice costs no time
// - Status written at the given status address plus one
// - Status word delivered is never zero
// - Success writes low byte 1, high 0
// - Failure puts major code above 1
// - Failure puts minor code in high byte
// - Errors also copied to diagnostic word one
`timescale 1ns/100ps
`default_nettype none
module srms_top
	import srms_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_rst,
	// Request from the CPU program
	input  wire logic                i_req_valid,
	input  wire logic                i_req_write,
	input  wire logic [7:0]          i_req_mem_type,
	input  wire logic [15:0]         i_req_addr,
	input  wire logic [15:0]         i_req_count,
	input  wire logic [7:0]          i_req_stat_type,
	input  wire logic [15:0]         i_req_stat_addr_m1,
	// Limit configuration
	input  wire logic                i_lim_wr,
	input  wire logic [3:0]          i_lim_area,
	input  wire logic [15:0]         i_lim_max,
	// Transfer engine handshake
	output logic                     o_xfer_start,
	output logic [3:0]               o_xfer_area,
	output logic [1:0]               o_xfer_unit,
	output logic                     o_xfer_write,
	output logic [15:0]              o_xfer_addr,
	output logic [15:0]              o_xfer_count,
	input  wire logic                i_xfer_done,
	input  wire logic [7:0]          i_xfer_major,
	input  wire logic [7:0]          i_xfer_minor,
	// Status word write-back
	output logic                     o_stat_wr,
	output logic [7:0]               o_stat_type,
	output logic [15:0]              o_stat_addr,
	output logic [15:0]              o_stat_word,
	// Diagnostic word one and state
	output logic [15:0]              o_diag_word1,
	output logic                     o_busy
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_XFER  = 4'b0100,
		ST_DONE  = 4'b1000
	} srms_state_e;

	typedef struct packed {
		srms_state_e state;
		logic        write;
		logic [3:0]  area;
		srms_unit_e  unit;
		logic [15:0] addr;
		logic [15:0] count;
		logic [7:0]  stype;
		logic [15:0] saddr;
		logic [7:0]  major;
		logic [7:0]  minor;
		logic        xfer_start;
		logic        stat_wr;
		logic [15:0] stat_word;
		logic [15:0] diag1;
		logic        busy;
	} srms_s;

	srms_s       st_r;
	srms_s       st_nxt;
	logic [15:0] lim_max;
	logic [3:0]  area;
	srms_unit_e  unit;
	logic [5:0]  req_code;
	logic [3:0]  rd_area;
	logic        range_ok;

	// Area index and access unit from a memory-type code
	function automatic logic [5:0] decode(input logic [7:0] c);
		unique case (c)
			MT_REG_WORD:  return {4'h0, UNIT_WORD};
			MT_AIN_WORD:  return {4'h1, UNIT_WORD};
			MT_AOUT_WORD: return {4'h2, UNIT_WORD};
			MT_IN_BIT:    return {4'h3, UNIT_BIT};
			MT_OUT_BIT:   return {4'h4, UNIT_BIT};
			MT_TMP_BIT:   return {4'h5, UNIT_BIT};
			MT_INT_BIT:   return {4'h6, UNIT_BIT};
			MT_SDA_BIT:   return {4'h7, UNIT_BIT};
			MT_SDB_BIT:   return {4'h8, UNIT_BIT};
			MT_SDC_BIT:   return {4'h9, UNIT_BIT};
			MT_SYS_BIT:   return {4'hA, UNIT_BIT};
			MT_GLB_BIT:   return {4'hB, UNIT_BIT};
			MT_IN_BYTE:   return {4'h3, UNIT_BYTE};
			MT_OUT_BYTE:  return {4'h4, UNIT_BYTE};
			MT_TMP_BYTE:  return {4'h5, UNIT_BYTE};
			MT_INT_BYTE:  return {4'h6, UNIT_BYTE};
			MT_SDA_BYTE:  return {4'h7, UNIT_BYTE};
			MT_SDB_BYTE:  return {4'h8, UNIT_BYTE};
			MT_SDC_BYTE:  return {4'h9, UNIT_BYTE};
			MT_SYS_BYTE:  return {4'hA, UNIT_BYTE};
			MT_GLB_BYTE:  return {4'hB, UNIT_BYTE};
			default:      return {AREA_NONE, UNIT_BAD};
		endcase
	endfunction

	// Bit and byte forms of one area share an index, so the limit is the
	// bit count; a byte request is scaled by eight before comparing.
	function automatic logic [19:0] in_bits(input logic [15:0] v,
		input srms_unit_e u);
		return (u == UNIT_BYTE) ? {1'b0, v, 3'h0} : {4'h0, v};
	endfunction

	assign area     = st_r.area;
	assign unit     = st_r.unit;
	assign req_code = decode(i_req_mem_type);
	// While idle the limit is read with the incoming code, so the value
	// stands ready in the check cycle; the held area is used afterwards
	assign rd_area  = (st_r.state == ST_IDLE) ? req_code[5:2] : st_r.area;

	srms_limit_mem u_lim (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.i_wr_en   (i_lim_wr),
		.i_wr_area (i_lim_area),
		.i_wr_max  (i_lim_max),
		.i_rd_area (rd_area),
		.o_rd_max  (lim_max)
	);

	// Last unit touched = (addr-1+count) in the area's own unit
	always_comb begin
		logic [19:0] last_u;
		logic [19:0] lim_u;
		last_u = 20'h00000;
		lim_u  = {4'h0, lim_max};
		last_u = 20'(in_bits(st_r.addr, unit) - 20'h00001)
			+ in_bits(st_r.count, unit);
		if (unit == UNIT_BYTE) begin
			last_u = 20'(in_bits(st_r.addr, unit) - 20'h00008)
				+ in_bits(st_r.count, unit);
		end
		range_ok = (st_r.addr >= ADDR_FIRST) && (st_r.count != 16'h0000)
			&& (last_u <= lim_u);
	end

	always_comb begin
		st_nxt            = st_r;
		st_nxt.xfer_start = 1'b0;
		st_nxt.stat_wr    = 1'b0;
		unique case (st_r.state)
			ST_IDLE: begin
				if (i_req_valid) begin
					st_nxt.write = i_req_write;
					st_nxt.area  = req_code[5:2];
					st_nxt.unit  = srms_unit_e'(req_code[1:0]);
					st_nxt.addr  = i_req_addr;
					st_nxt.count = i_req_count;
					st_nxt.stype = i_req_stat_type;
					st_nxt.saddr = 16'(i_req_stat_addr_m1 + 16'h0001);
					st_nxt.state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// Limit memory read data is valid here, one cycle after load
				if (unit == UNIT_BAD || !range_ok) begin
					st_nxt.major = MAJ_SRV_ERR;
					st_nxt.minor = MIN_BAD_PARAM;
					st_nxt.state = ST_DONE;
				end else if (st_r.write && area == 4'hA) begin
					st_nxt.major = MAJ_SRV_ERR;
					st_nxt.minor = MIN_NO_PRIV;
					st_nxt.state = ST_DONE;
				end else begin
					// Same handshake for bit and byte forms of an area
					st_nxt.xfer_start = 1'b1;
					st_nxt.state      = ST_XFER;
				end
			end
			ST_XFER: begin
				if (i_xfer_done) begin
					if (i_xfer_major == MAJ_OK) begin
						st_nxt.major = MAJ_OK;
						st_nxt.minor = MIN_NONE;
					end else if (i_xfer_major <= MAJ_OK) begin
						// A zero major code must not look like success
						st_nxt.major = MAJ_SRV_ERR;
						st_nxt.minor = MIN_ABORT;
					end else begin
						st_nxt.major = i_xfer_major;
						st_nxt.minor = i_xfer_minor;
					end
					st_nxt.state = ST_DONE;
				end
			end
			ST_DONE: begin
				st_nxt.stat_word = {st_r.minor, st_r.major};
				st_nxt.stat_wr   = 1'b1;
				if (st_r.major != MAJ_OK) begin
					st_nxt.diag1 = {st_r.minor, st_r.major};
				end
				st_nxt.state = ST_IDLE;
			end
		endcase
		st_nxt.busy = (st_nxt.state != ST_IDLE);
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '{state: ST_IDLE, area: AREA_NONE, unit: UNIT_BAD,
				stype: 8'h00, major: MAJ_OK, minor: MIN_NONE,
				stat_word: STATUS_RST, diag1: STATUS_RST, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_xfer_start = st_r.xfer_start;
	assign o_xfer_area  = st_r.area;
	assign o_xfer_unit  = st_r.unit;
	assign o_xfer_write = st_r.write;
	assign o_xfer_addr  = st_r.addr;
	assign o_xfer_count = st_r.count;
	assign o_stat_wr    = st_r.stat_wr;
	assign o_stat_type  = st_r.stype;
	assign o_stat_addr  = st_r.saddr;
	assign o_stat_word  = st_r.stat_word;
	assign o_diag_word1 = st_r.diag1;
	assign o_busy       = st_r.busy;
endmodule
`default_nettype wire

//--- verif/srms_checker.sv
// Port assertions for the memory-type decoder and status reporter.
// Assumes one clock domain; bound into srms_top below.
`timescale 1ns/100ps
`default_nettype none
module srms_checker
	import srms_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_req_valid,
	input  wire logic        i_req_write,
	input  wire logic [7:0]  i_req_mem_type,
	input  wire logic [15:0] i_req_addr,
	input  wire logic [15:0] i_req_count,
	input  wire logic        i_xfer_done,
	input  wire logic [7:0]  i_xfer_major,
	input  wire logic [7:0]  i_xfer_minor,
	input  wire logic        o_xfer_start,
	input  wire logic        o_stat_wr,
	input  wire logic [15:0] o_stat_word,
	input  wire logic [15:0] o_diag_word1,
	input  wire logic        o_busy
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic        take;
	logic [15:0] cap_r;
	assign take = i_req_valid && !o_busy;
	// Engine codes move between pulses, so keep the ones handed over
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			cap_r <= 16'h0000;
		else if (i_xfer_done)
			cap_r <= {i_xfer_minor, i_xfer_major};
	end
	AST_NONZERO: assert property (o_stat_wr |-> o_stat_word != 16'h0000)
		else $error("status word written as zero");
	AST_OK: assert property (o_busy && i_xfer_done && i_xfer_major == MAJ_OK
		|-> ##[1:3] (o_stat_wr && o_stat_word == 16'h0001))
		else $error("success status word wrong");
	AST_PASS: assert property (o_busy && i_xfer_done && i_xfer_major > MAJ_OK
		|-> ##[1:3] (o_stat_wr && o_stat_word == cap_r))
		else $error("engine error codes not reported");
	AST_MAJOR: assert property (o_stat_wr && o_stat_word != 16'h0001
		|-> o_stat_word[7:0] > MAJ_OK)
		else $error("error major code not above one");
	AST_DIAG: assert property (o_stat_wr && o_stat_word != 16'h0001
		|-> o_diag_word1 == o_stat_word)
		else $error("diagnostic word not updated");
	AST_RO: assert property (take && i_req_write && (i_req_mem_type ==
		MT_SYS_BIT || i_req_mem_type == MT_SYS_BYTE) |-> ##[1:4]
		(o_stat_wr && o_stat_word == {MIN_NO_PRIV, MAJ_SRV_ERR}))
		else $error("write to read-only area accepted");
	AST_RANGE: assert property (take && (i_req_addr == 0 ||
		i_req_count == 0) |-> ##[1:4] (o_stat_wr &&
		o_stat_word == {MIN_BAD_PARAM, MAJ_SRV_ERR}))
		else $error("zero address or count accepted");
	AST_ANSWER: assert property (take |-> ##[1:4] (o_xfer_start || o_stat_wr))
		else $error("request left unanswered");
endmodule
bind srms_top srms_checker srms_checker_i (.i_clock, .i_rst, .i_req_valid,
	.i_req_write, .i_req_mem_type, .i_req_addr, .i_req_count, .i_xfer_done,
	.i_xfer_major, .i_xfer_minor, .o_xfer_start, .o_stat_wr, .o_stat_word,
	.o_diag_word1, .o_busy);
`default_nettype wire

//--- verif/srms_engine_model.sv
// Transfer engine model: one done pulse with codes LAT cycles after start.
// Assumes the bench sets the codes before the request is made.
`timescale 1ns/100ps
`default_nettype none
module srms_engine_model #(parameter int LAT = 3) (
	input  wire logic       i_clock,
	input  wire logic       i_start,
	input  wire logic [7:0] i_major,
	input  wire logic [7:0] i_minor,
	output logic            o_done,
	output logic [7:0]      o_major,
	output logic [7:0]      o_minor
);
	int cnt = 0;
	initial {o_done, o_major, o_minor} = 17'h00000;
	always @(negedge i_clock) begin
		o_done <= 1'b0;
		// Codes are junk outside the pulse, so they keep changing
		{o_major, o_minor} <= ~{o_major, o_minor};
		if (i_start)
			cnt <= LAT;
		else if (cnt == 1)
			{o_done, o_major, o_minor} <= {1'b1, i_major, i_minor};
		if (!i_start && cnt > 0)
			cnt <= cnt - 1;
	end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the memory-type decoder and status reporter.
// Assumes the design, its checker bind and the engine model compile first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
	import srms_pkg::*;
	localparam logic [15:0] BAD = {MIN_BAD_PARAM, MAJ_SRV_ERR};
	localparam logic [15:0] NOPRIV = {MIN_NO_PRIV, MAJ_SRV_ERR};
	logic        i_clock = 0, i_rst = 1, rv = 0, rw = 0, lw = 0, dn, xs, sw, bz;
	logic        xw, sxw;
	logic [7:0]  rt = 0, mj = 8'h01, mn = 8'h00, emj, emn, st;
	logic [7:0]  sst, sty = 8'h08;
	logic [15:0] ra = 0, rc = 0, lm = 0, mem, sa, aw, wd, dg;
	logic [15:0] xa, xc, sxa, sxc, sam = 16'h0009;
	logic [3:0]  la = 0, ar, sar;
	logic [1:0]  un, sun;
	int          error_cnt = 0, cmp_count = 0, cy, cb;
	srms_top srms_top_i (.i_clock, .i_rst, .i_req_valid(rv), .i_req_write(rw),
		.i_req_mem_type(rt), .i_req_addr(ra), .i_req_count(rc),
		.i_req_stat_type(sty), .i_req_stat_addr_m1(sam),
		.i_lim_wr(lw), .i_lim_area(la), .i_lim_max(lm), .o_xfer_start(xs),
		.o_xfer_area(ar), .o_xfer_unit(un), .o_xfer_write(xw),
		.o_xfer_addr(xa), .o_xfer_count(xc), .i_xfer_done(dn),
		.i_xfer_major(emj),
		.i_xfer_minor(emn), .o_stat_wr(sw), .o_stat_type(st),
		.o_stat_addr(aw), .o_stat_word(wd), .o_diag_word1(dg), .o_busy(bz));
	srms_engine_model srms_engine_model_i (.i_clock, .i_start(xs),
		.i_major(mj), .i_minor(mn), .o_done(dn), .o_major(emj), .o_minor(emn));
	always #20 i_clock = ~i_clock;
	// Status memory of the requesting program
	always @(posedge i_clock) begin
		if (sw)
			{mem, sa, sst} <= {wd, aw, st};
		if (xs)
			{sar, sun, sxw, sxa, sxc} <= {ar, un, xw, xa, xc};
	end
	task automatic rq(input logic w, input logic [7:0] t,
			input logic [15:0] a, c, e);
		{mem, sun, cy} = {16'h0000, UNIT_BAD, 32'd0};
		@(negedge i_clock);
		{rv, rw, rt, ra, rc} = {1'b1, w, t, a, c};
		@(negedge i_clock);
		rv = 0;
		`CHK(bz, 1'b1)
		while (mem === 16'h0000 && cy < 50) begin
			@(negedge i_clock);
			cy++;
		end
		`CHK(mem, e)
		`CHK(sa, 16'(sam + 16'h0001))
		`CHK(sst, sty)
		if (sun !== UNIT_BAD)
			`CHK({sxw, sxa, sxc}, {w, a, c})
	endtask
	task automatic t_types();
		int k;
		for (k = 0; k < 3; k++) begin
			rq(0, 8'(8'h08 + 2 * k), 16'h0001, 16'h0002, 16'h0001);
			`CHK({sar, sun}, {4'(k), UNIT_WORD})
		end
		for (k = 0; k < 9; k++) begin
			rq(0, 8'(8'h46 + 2 * k), 16'h0009, 16'h0008, 16'h0001);
			cb = cy;
			`CHK({sar, sun}, {4'(3 + k), UNIT_BIT})
			rq(0, k < 8 ? 8'(8'h10 + 2 * k) : MT_GLB_BYTE, 16'h0002,
				16'h0001, 16'h0001);
			`CHK({sar, sun}, {4'(3 + k), UNIT_BYTE})
			`CHK(cy, cb)
		end
		$display("t_types done");
	endtask
	task automatic t_range();
		rq(0, MT_IN_BIT, 16'h2000, 16'h0001, 16'h0001);
		rq(0, MT_IN_BIT, 16'h2000, 16'h0002, BAD);
		rq(0, MT_IN_BYTE, 16'h0400, 16'h0001, 16'h0001);
		rq(0, MT_IN_BYTE, 16'h0400, 16'h0002, BAD);
		rq(0, MT_REG_WORD, 16'h0000, 16'h0001, BAD);
		rq(0, MT_REG_WORD, 16'h0001, 16'h0000, BAD);
		rq(0, 8'h09, 16'h0001, 16'h0001, BAD);
		@(negedge i_clock);
		{lw, la, lm} = {1'b1, 4'h0, 16'h0010};
		@(negedge i_clock);
		lw = 0;
		rq(0, MT_REG_WORD, 16'h0010, 16'h0001, 16'h0001);
		rq(0, MT_REG_WORD, 16'h0010, 16'h0002, BAD);
		$display("t_range done");
	endtask
	task automatic t_sys();
		rq(1, MT_SYS_BIT, 16'h0001, 16'h0001, NOPRIV);
		rq(1, MT_SYS_BYTE, 16'h0001, 16'h0001, NOPRIV);
		rq(0, MT_SYS_BYTE, 16'h0001, 16'h0001, 16'h0001);
		rq(1, MT_GLB_BYTE, 16'h0001, 16'h0001, 16'h0001);
		$display("t_sys done");
	endtask
	task automatic t_err();
		{sty, sam} = {8'h0A, 16'h0063};
		{mj, mn} = 16'h0C22;
		rq(0, MT_REG_WORD, 16'h0001, 16'h0001, 16'h220C);
		`CHK(dg, 16'h220C)
		{mj, mn} = 16'h0000;
		rq(0, MT_REG_WORD, 16'h0001, 16'h0001, 16'hFF05);
		{mj, mn} = 16'h0100;
		rq(0, MT_REG_WORD, 16'h0001, 16'h0001, 16'h0001);
		`CHK(dg, 16'hFF05)
		{mj, mn} = 16'h0700;
		rq(0, MT_REG_WORD, 16'h0001, 16'h0001, 16'h0007);
		`CHK(dg, 16'h0007)
		// Nothing is sent after the queue-full answer in this run
		$display("t_err done");
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge i_clock);
		i_rst = 0;
		t_types();
		t_range();
		t_sys();
		t_err();
		conclude();
	end
	initial begin
		#(40 * 6000);
		error_cnt++;
		$display("Error %0t: watchdog ran out", $time);
		conclude();
	end
endmodule
`default_nettype wire
